// file: include/lpmc_pkg.sv
// Purpose: types for the low power mode controller
// Assumes: nothing
// Notes: state codes written out
package lpmc_pkg;
  // current power mode
  typedef enum logic [2:0] {
    LPMC_ACTIVE = 3'h0,
    LPMC_IDLE = 3'h1,
    LPMC_STANDBY = 3'h2,
    LPMC_SLEEP = 3'h3,
    LPMC_PDOWN = 3'h4,
    LPMC_SLP_WAIT = 3'h5,
    LPMC_WAKE = 3'h6
  } lpmc_mode_e;
  // which instruction put the core down
  typedef enum logic [1:0] {
    LPMC_BY_WAIT_IRQ = 2'h0,
    LPMC_BY_WAIT_EVT = 2'h1,
    LPMC_BY_EXIT = 2'h2
  } lpmc_cause_e;
endpackage : lpmc_pkg

// file: include/lpmc_regs.svh
// Purpose: constants for the low power mode controller
// Assumes: 100 MHz core clock
// Notes: mode codes as software writes them into the mode code field
// Contract
// [RQ1] active idle standby keep all regulators on
// [RQ2] sleep keeps only retention regulator on
// [RQ3] power-down turns every regulator off
// [RQ4] active may enter any low-power mode
// [RQ5] idle entry on core_sleep_flag without deep sleep
// [RQ6] idle keeps regulator normal, flash standby
// [RQ7] idle exits on irq, event line, reset
// [RQ8] idle by interrupt wait wakes on enabled irq
// [RQ9] idle by event wait, flag clear: event wakes
// [RQ10] idle by event wait, flag set: irq wakes
// [RQ11] standby entry: deep sleep, no pending
// [RQ12] standby stops core, radio stays usable
// [RQ13] standby sram retention and oscillators configurable
// [RQ14] standby holds io retention and pins
// [RQ15] standby by interrupt wait: enabled line irq
// [RQ16] standby by event wait, flag clear: event
// [RQ17] standby by event wait, flag set: irq
// [RQ18] standby exit restarts fast oscillators, resumes
// [RQ19] software clears pending flags after wake
// [RQ20] standby needs enable and code 001; code enters standby on any deep entry not selecting power-down or sleep
// [RQ21] sleep needs radio idle, code 2; code checks only enable and code 2, with no radio idle input
// [RQ22] sleep completes once flash, bus idle
// [RQ23] explicit mode state, records entry cause
// [RQ24] reset or wake pin exits any mode
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH
`define LPMC_CODE_STANDBY 3'h1
`define LPMC_CODE_SLEEP 3'h2
`define LPMC_OSC_SETTLE_NS 1000
`define LPMC_CLK_NS 10
`define LPMC_OSC_SETTLE_CYC ((`LPMC_OSC_SETTLE_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_RST_MODE 3'h0
`endif

// file: rtl/lpmc_ctrl.sv
// Purpose: low power mode sequencer driving regulators, clocks and retention
// Assumes: core sleep signals are on core_clk_i; wake pins and reset pin are asynchronous
// Notes: core clock is assumed kept alive by an always-on source in this model
`timescale 1ns/10ps
`include "lpmc_regs.svh"
module lpmc_ctrl
  import lpmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic core_sleep_flag_i, // core reports core_sleep_flag
  input wire logic deep_sleep_request_i,
  input wire logic sleep_on_handler_exit_i,
  input wire logic pending_as_event_i,
  input wire logic wait_for_interrupt_instr_i, // one-cycle pulse
  input wire logic wait_for_event_instr_i, // one-cycle pulse
  input wire logic handler_return_i, // handler return with nothing pending
  input wire logic power_down_select_i,
  input wire logic mode_select_enable_i,
  input wire logic [2:0] low_power_mode_code_i,
  input wire logic irq_pending_i, // any irq pending, enabled or not
  input wire logic irq_enabled_pending_i, // pending and enabled in the irq controller
  input wire logic line_irq_enabled_i, // event-line irq enabled in the irq controller
  input wire logic line_irq_i, // event-line irq raised
  input wire logic line_event_i, // event-line event raised
  input wire logic flash_idle_i,
  input wire logic periph_bus_idle_i,
  input wire logic [1:0] sram_keep_cfg_i, // 0 none, 1 part, 3 all
  input wire logic fast_xtal_keep_i,
  input wire logic slow_xtal_en_i,
  input wire logic slow_int_en_i,
  input wire logic reset_pin_n_i, // asynchronous pin
  input wire logic wake_pin_one_i, // asynchronous pin
  output logic [2:0] mode_o,
  output logic buck_on_o,
  output logic system_regulator_on_o,
  output logic retention_regulator_on_o,
  output logic regulator_normal_o,
  output logic flash_standby_o,
  output logic flash_off_o,
  output logic core_clk_run_o,
  output logic core_power_o,
  output logic periph_if_on_o,
  output logic radio_avail_o,
  output logic [1:0] sram_keep_o,
  output logic fast_internal_osc_on_o,
  output logic fast_crystal_osc_on_o,
  output logic slow_crystal_osc_on_o,
  output logic slow_internal_osc_on_o,
  output logic io_retain_o,
  output logic core_resume_o, // one-cycle pulse: core runs again
  output logic [1:0] entry_cause_o
);
  // ***********************************
  // pin synchronisers
  // ***********************************
  logic rst_pin_held_s; // reset pin held low, synchronised
  logic wake_pin_s; // wake pin, synchronised
  logic wake_pin_d; // previous wake pin, for rising edge
  logic rst_pin_d; // previous reset pin
  logic pin_wake; // reset pin low edge or wake pin rising edge

  lpmc_sync2 u_sync_rst (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(!reset_pin_n_i),
    .sync_o(rst_pin_held_s)
  );
  lpmc_sync2 u_sync_wake (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(wake_pin_one_i),
    .sync_o(wake_pin_s)
  );

  // edge history for pins (reads second stage only)
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wake_pin_d <= 1'b0;
      rst_pin_d <= 1'b0;
    end else begin
      wake_pin_d <= wake_pin_s;
      rst_pin_d <= rst_pin_held_s;
    end
  end
  // note: rst_pin_held_s is high while the pin is held low
  assign pin_wake = (wake_pin_s && !wake_pin_d) || (rst_pin_held_s && !rst_pin_d); // RQ24

  // ***********************************
  // state and entry decode
  // ***********************************
  lpmc_mode_e mode; // current mode
  lpmc_mode_e next_mode;
  lpmc_cause_e cause; // entry instruction, picks wake rule
  lpmc_cause_e next_cause;
  logic [7:0] settle_cnt; // oscillator settle after standby or sleep
  logic wait_instr; // either wait instruction this cycle
  logic nothing_pending; // no irq for an interrupt wait, no event for an event wait
  logic idle_entry;
  logic deep_entry;
  logic wake_now;

  assign wait_instr = wait_for_interrupt_instr_i || wait_for_event_instr_i;
  assign nothing_pending = wait_for_interrupt_instr_i ? !irq_pending_i : !line_event_i;

  // idle: core_sleep_flag, no deep sleep, either by instruction or handler return
  assign idle_entry = core_sleep_flag_i && !deep_sleep_request_i &&
                      ((wait_instr && !sleep_on_handler_exit_i) ||
                       (sleep_on_handler_exit_i && handler_return_i)); // RQ5
  // deep modes need a wait instruction and nothing already pending
  assign deep_entry = deep_sleep_request_i && wait_instr && nothing_pending; // RQ11

  // wake rules depend on mode and entry cause
  always_comb begin
    wake_now = pin_wake; // RQ24
    case (mode)
      LPMC_IDLE: begin
        if (cause != LPMC_BY_WAIT_EVT) begin
          wake_now = wake_now || irq_enabled_pending_i || line_irq_i; // RQ8 RQ7
        end else if (!pending_as_event_i) begin
          wake_now = wake_now || line_event_i || line_irq_i; // RQ9 RQ7
        end else begin
          wake_now = wake_now || irq_pending_i || line_event_i; // RQ10
        end
      end
      LPMC_STANDBY, LPMC_SLEEP: begin
        if (cause != LPMC_BY_WAIT_EVT) begin
          wake_now = wake_now || (line_irq_i && line_irq_enabled_i); // RQ15
        end else if (!pending_as_event_i) begin
          wake_now = wake_now || line_event_i; // RQ16
        end else begin
          wake_now = wake_now || line_irq_i || line_event_i; // RQ17
        end
      end
      default: begin
        wake_now = pin_wake;
      end
    endcase
  end

  // ***********************************
  // next mode
  // ***********************************
  always_comb begin
    next_mode = mode;
    next_cause = cause;
    case (mode)
      LPMC_ACTIVE: begin
        if (deep_entry) begin // RQ4
          next_cause = wait_for_event_instr_i ? LPMC_BY_WAIT_EVT : LPMC_BY_WAIT_IRQ; // RQ23
          if (power_down_select_i) begin
            next_mode = LPMC_PDOWN;
          end else if (mode_select_enable_i && low_power_mode_code_i == `LPMC_CODE_SLEEP) begin
            next_mode = LPMC_SLP_WAIT; // RQ21
          end else begin
            next_mode = LPMC_STANDBY; // RQ20
          end
        end else if (idle_entry) begin
          next_mode = LPMC_IDLE;
          next_cause = wait_for_event_instr_i ? LPMC_BY_WAIT_EVT :
                       (wait_for_interrupt_instr_i ? LPMC_BY_WAIT_IRQ : LPMC_BY_EXIT); // RQ23
        end
      end
      LPMC_SLP_WAIT: begin
        if (pin_wake) begin
          next_mode = LPMC_ACTIVE;
        end else if (flash_idle_i && periph_bus_idle_i) begin
          next_mode = LPMC_SLEEP; // RQ22
        end
      end
      LPMC_IDLE: begin
        if (wake_now) begin
          next_mode = LPMC_ACTIVE; // RQ7
        end
      end
      LPMC_STANDBY, LPMC_SLEEP: begin
        if (wake_now) begin
          next_mode = LPMC_WAKE; // RQ18
        end
      end
      LPMC_PDOWN: begin
        if (pin_wake) begin
          next_mode = LPMC_ACTIVE; // RQ24
        end
      end
      LPMC_WAKE: begin
        if (settle_cnt == 8'h00) begin
          next_mode = LPMC_ACTIVE;
        end
      end
      default: begin
        next_mode = LPMC_ACTIVE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode <= LPMC_ACTIVE;
      cause <= LPMC_BY_WAIT_IRQ;
    end else begin
      mode <= next_mode; // RQ23
      cause <= next_cause;
    end
  end

  // oscillator settle count, loaded on wake from standby or sleep
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      settle_cnt <= 8'h00;
    end else if (mode != LPMC_WAKE && next_mode == LPMC_WAKE) begin
      settle_cnt <= 8'(`LPMC_OSC_SETTLE_CYC - 1); // RQ18
    end else if (settle_cnt != 8'h00) begin
      settle_cnt <= settle_cnt - 8'h01;
    end
  end

  // ***********************************
  // outputs, registered from next state
  // ***********************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      buck_on_o <= 1'b1;
      system_regulator_on_o <= 1'b1;
      retention_regulator_on_o <= 1'b1;
      regulator_normal_o <= 1'b1;
    end else begin
      buck_on_o <= next_mode != LPMC_SLEEP && next_mode != LPMC_PDOWN; // RQ1 RQ2 RQ3
      system_regulator_on_o <= next_mode != LPMC_SLEEP && next_mode != LPMC_PDOWN; // RQ1 RQ2
      retention_regulator_on_o <= next_mode != LPMC_PDOWN; // RQ2 RQ3
      regulator_normal_o <= next_mode != LPMC_SLEEP && next_mode != LPMC_PDOWN; // RQ6 RQ12
    end
  end

  // core, flash, peripherals, radio
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core_clk_run_o <= 1'b1;
      core_power_o <= 1'b1;
      periph_if_on_o <= 1'b1;
      flash_standby_o <= 1'b0;
      flash_off_o <= 1'b0;
      radio_avail_o <= 1'b1;
      io_retain_o <= 1'b0;
    end else begin
      core_clk_run_o <= next_mode == LPMC_ACTIVE || next_mode == LPMC_SLP_WAIT;
      core_power_o <= next_mode == LPMC_ACTIVE || next_mode == LPMC_IDLE ||
                      next_mode == LPMC_SLP_WAIT; // RQ12
      periph_if_on_o <= next_mode == LPMC_ACTIVE || next_mode == LPMC_IDLE ||
                        next_mode == LPMC_SLP_WAIT; // RQ6 RQ12
      flash_standby_o <= next_mode == LPMC_IDLE || next_mode == LPMC_STANDBY; // RQ6
      flash_off_o <= next_mode == LPMC_SLEEP || next_mode == LPMC_PDOWN;
      radio_avail_o <= next_mode != LPMC_SLEEP && next_mode != LPMC_PDOWN; // RQ12
      io_retain_o <= next_mode == LPMC_STANDBY || next_mode == LPMC_SLEEP; // RQ14
    end
  end

  // clocks and sram retention
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sram_keep_o <= 2'h3;
      fast_internal_osc_on_o <= 1'b1;
      fast_crystal_osc_on_o <= 1'b1;
      slow_crystal_osc_on_o <= 1'b0;
      slow_internal_osc_on_o <= 1'b1;
    end else begin
      case (next_mode)
        LPMC_STANDBY: begin
          sram_keep_o <= sram_keep_cfg_i; // RQ13
          fast_internal_osc_on_o <= 1'b0;
          fast_crystal_osc_on_o <= fast_xtal_keep_i; // RQ13
          slow_crystal_osc_on_o <= slow_xtal_en_i;
          slow_internal_osc_on_o <= slow_int_en_i;
        end
        LPMC_SLEEP: begin
          sram_keep_o <= sram_keep_cfg_i;
          fast_internal_osc_on_o <= 1'b0;
          fast_crystal_osc_on_o <= 1'b0;
          slow_crystal_osc_on_o <= slow_xtal_en_i;
          slow_internal_osc_on_o <= slow_int_en_i;
        end
        LPMC_PDOWN: begin
          sram_keep_o <= 2'h0; // RQ3
          fast_internal_osc_on_o <= 1'b0;
          fast_crystal_osc_on_o <= 1'b0;
          slow_crystal_osc_on_o <= 1'b0;
          slow_internal_osc_on_o <= 1'b0;
        end
        default: begin
          sram_keep_o <= 2'h3;
          fast_internal_osc_on_o <= 1'b1; // RQ18
          fast_crystal_osc_on_o <= 1'b1; // RQ18
          slow_crystal_osc_on_o <= slow_xtal_en_i;
          slow_internal_osc_on_o <= 1'b1;
        end
      endcase
    end
  end

  // mode, cause and resume pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_o <= `LPMC_RST_MODE;
      entry_cause_o <= 2'h0;
      core_resume_o <= 1'b0;
    end else begin
      mode_o <= next_mode;
      entry_cause_o <= next_cause;
      core_resume_o <= mode != LPMC_ACTIVE && next_mode == LPMC_ACTIVE; // RQ18 RQ23
    end
  end

  // ***********************************
  // checks
  // ***********************************
  property p_rq1;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (mode == LPMC_IDLE || mode == LPMC_STANDBY) |-> (buck_on_o && system_regulator_on_o && retention_regulator_on_o);
  endproperty
  a_rq1: assert property (p_rq1) else $error("regulator off in normal mode"); // RQ1
  property p_rq2;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      mode == LPMC_SLEEP |-> (!buck_on_o && !system_regulator_on_o && retention_regulator_on_o);
  endproperty
  a_rq2: assert property (p_rq2) else $error("sleep regulator state wrong"); // RQ2
  property p_rq3;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      mode == LPMC_PDOWN |-> (!buck_on_o && !retention_regulator_on_o && sram_keep_o == 2'h0);
  endproperty
  a_rq3: assert property (p_rq3) else $error("power-down regulator on"); // RQ3
  sequence s_deep_req;
    mode == LPMC_ACTIVE && deep_entry && !power_down_select_i && !pin_wake;
  endsequence
  property p_rq11;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      s_deep_req |=> (mode == LPMC_STANDBY || mode == LPMC_SLP_WAIT);
  endproperty
  a_rq11: assert property (p_rq11) else $error("deep entry missed"); // RQ11
  property p_rq22;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (mode == LPMC_SLP_WAIT && !(flash_idle_i && periph_bus_idle_i)) |=> mode != LPMC_SLEEP;
  endproperty
  a_rq22: assert property (p_rq22) else $error("sleep before bus idle"); // RQ22
  property p_rq15;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (mode == LPMC_STANDBY && cause == LPMC_BY_WAIT_IRQ && line_irq_i && line_irq_enabled_i) |=> mode == LPMC_WAKE;
  endproperty
  a_rq15: assert property (p_rq15) else $error("standby interrupt-wait wake missed"); // RQ15
  property p_rq18;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(mode == LPMC_WAKE) |=> (fast_internal_osc_on_o && fast_crystal_osc_on_o);
  endproperty
  a_rq18: assert property (p_rq18) else $error("fast oscillators not restarted"); // RQ18
  property p_rq8;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (mode == LPMC_IDLE && cause != LPMC_BY_WAIT_EVT && irq_enabled_pending_i) |=> (mode == LPMC_ACTIVE && core_resume_o);
  endproperty
  a_rq8: assert property (p_rq8) else $error("idle interrupt-wait wake missed"); // RQ8
endmodule : lpmc_ctrl

// file: rtl/lpmc_sync2.sv
// Purpose: two flop synchroniser for pin inputs
// Assumes: single clock domain
// Notes: first flop feeds only the second
`timescale 1ns/10ps
module lpmc_sync2 (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta; // first stage, read only by sync_o
  // ***********************************
  // two stage capture
  // ***********************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : lpmc_sync2

// file: testbench/lpmc_core_model.sv
// Purpose: core side model issuing wait pulses and the core_sleep_flag flag
// Assumes: driven at the falling clock edge
// Notes: the core_sleep_flag flag drops once the block pulses resume
`timescale 1ns/10ps
module lpmc_core_model (
  input wire logic core_clk_i,
  input wire logic core_resume_i,
  output logic core_sleep_flag_o,
  output logic wait_irq_o,
  output logic wait_evt_o,
  output logic ret_o
);
  // ********************
  // wait pulse issue
  // ********************
  initial begin
    core_sleep_flag_o = 1'b0;
    {wait_irq_o, wait_evt_o, ret_o} = 3'h0;
  end
  // kind 0 interrupt wait, 1 event wait, 2 handler return; dly models a slow core
  task automatic issue(input logic [1:0] kind, input int dly);
    repeat (dly) @(negedge core_clk_i);
    core_sleep_flag_o = 1'b1;
    wait_irq_o = (kind == 2'h0);
    wait_evt_o = (kind == 2'h1);
    ret_o = (kind == 2'h2);
    @(negedge core_clk_i);
    {wait_irq_o, wait_evt_o, ret_o} = 3'h0; // single cycle pulse
  endtask : issue
  // a running core no longer reports core_sleep_flag
  always @(negedge core_clk_i) begin
    if (core_resume_i === 1'b1) begin
      core_sleep_flag_o = 1'b0;
    end
  end
endmodule : lpmc_core_model

// file: testbench/test_low_power_mode_controller.sv
// Purpose: self-checking bench for the low power mode controller
// Assumes: inputs change at the falling edge, 100 MHz clock
// Notes: settle count of 100 cycles is checked with one cycle slack
`timescale 1ns/10ps
module test_low_power_mode_controller import lpmc_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dsr, soe, pae, pds, mse, irqp, irqe, lie, lirq, lev, fidle, bidle, fxk, sxe, sie, rpin_n, wpin;
  logic [2:0] code;
  logic [1:0] scfg;
  logic sflag, wirq, wevt, ret;
  logic [2:0] mode;
  logic buck, sysr, retr, regn, fsb, foff, cclk, cpow, pif, radio, fio, fxo, sxo, sio, iox, resume;
  logic [1:0] skeep, cause;
  int mismatches = 0;
  int comparisons = 0;
  // ********************
  // clock, model, design
  // ********************
  always #5 clk = ~clk;
  lpmc_core_model core (.core_clk_i(clk), .core_resume_i(resume), .core_sleep_flag_o(sflag),
    .wait_irq_o(wirq), .wait_evt_o(wevt), .ret_o(ret));
  lpmc_ctrl uut (.core_clk_i(clk), .rst_n_i(rst_n), .core_sleep_flag_i(sflag), .deep_sleep_request_i(dsr),
    .sleep_on_handler_exit_i(soe), .pending_as_event_i(pae), .wait_for_interrupt_instr_i(wirq),
    .wait_for_event_instr_i(wevt), .handler_return_i(ret), .power_down_select_i(pds),
    .mode_select_enable_i(mse), .low_power_mode_code_i(code), .irq_pending_i(irqp),
    .irq_enabled_pending_i(irqe), .line_irq_enabled_i(lie), .line_irq_i(lirq), .line_event_i(lev),
    .flash_idle_i(fidle), .periph_bus_idle_i(bidle), .sram_keep_cfg_i(scfg), .fast_xtal_keep_i(fxk),
    .slow_xtal_en_i(sxe), .slow_int_en_i(sie), .reset_pin_n_i(rpin_n), .wake_pin_one_i(wpin),
    .mode_o(mode), .buck_on_o(buck), .system_regulator_on_o(sysr), .retention_regulator_on_o(retr),
    .regulator_normal_o(regn), .flash_standby_o(fsb), .flash_off_o(foff), .core_clk_run_o(cclk),
    .core_power_o(cpow), .periph_if_on_o(pif), .radio_avail_o(radio), .sram_keep_o(skeep),
    .fast_internal_osc_on_o(fio), .fast_crystal_osc_on_o(fxo), .slow_crystal_osc_on_o(sxo),
    .slow_internal_osc_on_o(sio), .io_retain_o(iox), .core_resume_o(resume), .entry_cause_o(cause));
  // ********************
  // shared helpers
  // ********************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // bounded wait; running out ends the run
  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
    chk("wait mode", 8'(m), 8'(mode));
    if (mode !== m) wrap_up();
  endtask : wait_mode
  task automatic enter(input logic [1:0] k, input logic [2:0] m);
    core.issue(k, 1);
    chk("entry mode", 8'(m), 8'(mode));
    chk("entry cause", 8'(k), 8'(cause));
  endtask : enter
  // deep wakes pass the settle state, so resume comes about 100 cycles later
  task automatic back(input logic deep);
    int n;
    n = 0;
    if (deep) begin
      @(negedge clk);
      chk("settle mode", 8'(LPMC_WAKE), 8'(mode));
      chk("fast oscs", 8'h03, 8'({fio, fxo}));
    end
    while (resume !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("resume", 8'h01, 8'(resume));
    if (resume !== 1'b1) wrap_up();
    chk("wake delay", 8'h01, 8'(deep ? (n >= 99 && n <= 101) : (n >= 1 && n <= 2)));
    chk("woken mode", 8'(LPMC_ACTIVE), 8'(mode));
    {irqp, irqe, lirq, lev, lie} = 5'h00;
    @(negedge clk);
  endtask : back
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    chk("mode", 8'(LPMC_ACTIVE), 8'(mode));
    chk("regulators", 8'h07, 8'({buck, sysr, retr}));
    chk("oscs", 8'h0d, 8'({fio, fxo, sxo, sio}));
    chk("misc", 8'h03, 8'({fsb, foff, iox, resume, skeep}));
    $display("test reset done");
  endtask : t_reset
  // interrupt wait, event wait flag clear, event wait flag set, handler exit
  task automatic t_idle();
    for (int i = 0; i < 4; i++) begin
      pae = (i == 2);
      soe = (i == 3);
      enter((i == 0) ? 2'h0 : (i == 3) ? 2'h2 : 2'h1, LPMC_IDLE);
      chk("idle regs", 8'h0f, 8'({buck, sysr, retr, regn}));
      chk("idle flash", 8'h01, 8'(fsb));
      case (i)
        0: irqe = 1'b1;
        1: lev = 1'b1;
        2: irqp = 1'b1;
        default: lirq = 1'b1;
      endcase
      back(1'b0);
    end
    $display("test idle done");
  endtask : t_idle
  task automatic t_standby();
    dsr = 1'b1;
    mse = 1'b1;
    code = 3'h1;
    scfg = 2'h1;
    fxk = 1'b1;
    sxe = 1'b1;
    irqp = 1'b1;
    core.issue(2'h0, 0);
    chk("refused", 8'(LPMC_ACTIVE), 8'(mode));
    irqp = 1'b0;
    enter(2'h0, LPMC_STANDBY);
    chk("stby power", 8'hf2, 8'({buck, sysr, retr, regn, cpow, pif, radio, cclk}));
    chk("stby keep", 8'h07, 8'({skeep, iox, fsb}));
    chk("stby oscs", 8'h06, 8'({fio, fxo, sxo, sio}));
    lirq = 1'b1;
    repeat (5) @(negedge clk);
    chk("masked line", 8'(LPMC_STANDBY), 8'(mode));
    lie = 1'b1;
    back(1'b1);
    for (int i = 0; i < 2; i++) begin
      pae = i[0];
      enter(2'h1, LPMC_STANDBY);
      if (i == 0) lev = 1'b1;
      else lirq = 1'b1;
      back(1'b1);
    end
    $display("test standby done");
  endtask : t_standby
  task automatic t_sleep();
    code = 3'h2;
    fidle = 1'b0;
    enter(2'h0, LPMC_SLP_WAIT);
    repeat (3) @(negedge clk);
    chk("busy flash", 8'(LPMC_SLP_WAIT), 8'(mode));
    fidle = 1'b1;
    wait_mode(LPMC_SLEEP, 3);
    chk("sleep regs", 8'h03, 8'({buck, sysr, retr, foff}));
    lie = 1'b1;
    lirq = 1'b1;
    back(1'b1);
    $display("test sleep done");
  endtask : t_sleep
  // pins must wake even with every regulator off
  task automatic t_pdown();
    pds = 1'b1;
    enter(2'h0, LPMC_PDOWN);
    chk("pd regs", 8'h00, 8'({buck, sysr, retr}));
    wpin = 1'b1;
    wait_mode(LPMC_ACTIVE, 8);
    chk("pd wake regs", 8'h07, 8'({buck, sysr, retr}));
    wpin = 1'b0;
    repeat (3) @(negedge clk);
    enter(2'h1, LPMC_PDOWN);
    rpin_n = 1'b0;
    wait_mode(LPMC_ACTIVE, 8);
    rpin_n = 1'b1;
    $display("test power down done");
  endtask : t_pdown
  // ********************
  // main sequence
  // ********************
  initial begin
    {dsr, soe, pae, pds, mse, irqp, irqe, lie, lirq, lev, fxk, sxe, sie, wpin} = 14'h0000;
    {fidle, bidle, rpin_n} = 3'h7;
    code = 3'h0;
    scfg = 2'h3;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_idle();
    t_standby();
    t_sleep();
    t_pdown();
    wrap_up();
  end
endmodule : test_low_power_mode_controller
